// [hdl/tqprm_top.sv]
// Register bank and decoder mapping 64 egress queues onto transmit ports.
// Assumes an Avalon-MM master on core_clk and a queuing engine reading the map.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module tqprm_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                                                core_clk,
  input  wire logic                                                rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]                                   address,
  input  wire logic                                                read,
  input  wire logic                                                write,
  input  wire logic [31:0]                                         writedata,
  input  wire logic [3:0]                                          byteenable,
  output logic      [31:0]                                         readdata,
  output logic      [1:0]                                          response,
  output logic                                                     waitrequest,
  // Queue to port map
  output logic      [tqprm_pkg::NUM_QUEUES*tqprm_pkg::PORT_W-1:0]  queuePort,
  output logic      [tqprm_pkg::NUM_QUEUES-1:0]                    queueValid
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte-lane merge for the 16-bit registers; the upper lanes are ignored.
  function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = data[7:0];
    end
    if (be[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : mergeBytes

  // Compares a byte address with a register index, so misaligned addresses never hit.
  function automatic logic hitIndex(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    logic [ADDR_W+1:0] byteAddr;
    byteAddr = {idx[ADDR_W-1:0], 2'b00};
    return ({2'b00, addr} == byteAddr);
  endfunction : hitIndex

  // Population count of the valid map for the status word.
  function automatic logic [tqprm_pkg::COUNT_W-1:0] countOnes(input logic [tqprm_pkg::NUM_QUEUES-1:0] v);
    logic [tqprm_pkg::COUNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < tqprm_pkg::NUM_QUEUES; i++) begin
      n = n + {6'h00, v[i]};
    end
    return n;
  endfunction : countOnes

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]                    routeBottomFf;
  logic [15:0]                    routeLowerMidFf;
  logic [15:0]                    routeUpperMidFf;
  logic [15:0]                    routeTopFf;
  logic [1:0]                     portModeFf;
  logic                           fullGroupFf;
  logic                           ackFf;
  logic [31:0]                    readdataFf;
  logic [1:0]                     responseFf;
  logic [tqprm_pkg::NUM_QUEUES-1:0] routeAll;

  // One select per register; an unmapped address matches none of them.
  logic selBottom;
  logic selLowerMid;
  logic selUpperMid;
  logic selTop;
  logic selConfig;
  logic selStatus;
  logic doWrite;

  assign selBottom   = hitIndex(address, tqprm_pkg::REG_IDX_ROUTE_BOTTOM);
  assign selLowerMid = hitIndex(address, tqprm_pkg::REG_IDX_ROUTE_LOWER_MID);
  assign selUpperMid = hitIndex(address, tqprm_pkg::REG_IDX_ROUTE_UPPER_MID);
  assign selTop      = hitIndex(address, tqprm_pkg::REG_IDX_ROUTE_TOP);
  assign selConfig   = hitIndex(address, tqprm_pkg::REG_IDX_PORT_CONFIG);
  assign selStatus   = hitIndex(address, tqprm_pkg::REG_IDX_MAP_STATUS);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Every access stalls exactly one cycle so that read data come from a flop.
  // A write lands on the completing edge, so the map moves in the cycle after it.
  assign waitrequest = (read | write) & ~ackFf;
  assign doWrite     = write & ackFf;
  assign readdata    = readdataFf;
  assign response    = responseFf;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackFf <= 1'b0;
    end else begin
      ackFf <= (read | write) & ~ackFf;
    end
  end

  // ----------------------------------------------------------------
  // Routing registers
  // ----------------------------------------------------------------
  // Only byte lanes 0 and 1 carry routing bits; lanes 2 and 3 are dropped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      routeBottomFf <= tqprm_pkg::ROUTE_RESET;
    end else if (doWrite && selBottom) begin
      routeBottomFf <= mergeBytes(routeBottomFf, writedata, byteenable);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      routeLowerMidFf <= tqprm_pkg::ROUTE_RESET;
    end else if (doWrite && selLowerMid) begin
      routeLowerMidFf <= mergeBytes(routeLowerMidFf, writedata, byteenable);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      routeUpperMidFf <= tqprm_pkg::ROUTE_RESET;
    end else if (doWrite && selUpperMid) begin
      routeUpperMidFf <= mergeBytes(routeUpperMidFf, writedata, byteenable);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      routeTopFf <= tqprm_pkg::ROUTE_RESET;
    end else if (doWrite && selTop) begin
      routeTopFf <= mergeBytes(routeTopFf, writedata, byteenable);
    end
  end

  // ----------------------------------------------------------------
  // Port configuration
  // ----------------------------------------------------------------
  // Mode and full-group select share lane 0; a write without it changes neither.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      portModeFf  <= tqprm_pkg::MODE_RESET;
      fullGroupFf <= tqprm_pkg::FULL_GROUP_RESET;
    end else if (doWrite && selConfig && byteenable[0]) begin
      portModeFf  <= writedata[tqprm_pkg::CFG_MODE_LSB +: 2];
      fullGroupFf <= writedata[tqprm_pkg::CFG_FULL_GROUP];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data are captured in the stall cycle and stand at the completing edge.
  // The status word counts the queues that the current mode routes to a port.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdataFf <= 32'h0000_0000;
      responseFf <= tqprm_pkg::RESP_OKAY;
    end else if ((read | write) && !ackFf) begin
      readdataFf <= 32'h0000_0000;
      responseFf <= tqprm_pkg::RESP_OKAY;
      if (!read) begin
        readdataFf <= 32'h0000_0000;
      end else if (selBottom) begin
        readdataFf[15:0] <= routeBottomFf;
      end else if (selLowerMid) begin
        readdataFf[15:0] <= routeLowerMidFf;
      end else if (selUpperMid) begin
        readdataFf[15:0] <= routeUpperMidFf;
      end else if (selTop) begin
        readdataFf[15:0] <= routeTopFf;
      end else if (selConfig) begin
        readdataFf[tqprm_pkg::CFG_MODE_LSB +: 2] <= portModeFf;
        readdataFf[tqprm_pkg::CFG_FULL_GROUP]    <= fullGroupFf;
      end else if (selStatus) begin
        readdataFf[tqprm_pkg::STATUS_COUNT_LSB +: tqprm_pkg::COUNT_W] <= countOnes(queueValid);
      end else begin
        responseFf <= tqprm_pkg::RESP_DECODE_ERROR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Queue to port decode
  // ----------------------------------------------------------------
  // Each instance turns one routing bit and the shared mode into a port number.
  assign routeAll = {routeTopFf, routeUpperMidFf, routeLowerMidFf, routeBottomFf};

  for (genvar q = 0; q < tqprm_pkg::NUM_QUEUES; q++) begin : gQueue
    tqprm_queue_port #(
      .QUEUE (q)
    ) uQueuePort (
      .routeBit  (routeAll[q]),
      .portMode  (portModeFf),
      .fullGroup (fullGroupFf),
      .port      (queuePort[q*tqprm_pkg::PORT_W +: tqprm_pkg::PORT_W]),
      .valid     (queueValid[q])
    );
  end

endmodule : tqprm_top

// [shared/tqprm_pkg.sv]
// Constants for the transmit queue to port routing map.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package tqprm_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_IDX_ROUTE_TOP       = 16'h0178;
  localparam logic [15:0] REG_IDX_ROUTE_UPPER_MID = 16'h017a;
  localparam logic [15:0] REG_IDX_ROUTE_LOWER_MID = 16'h017c;
  localparam logic [15:0] REG_IDX_ROUTE_BOTTOM    = 16'h017e;
  localparam logic [15:0] REG_IDX_PORT_CONFIG     = 16'h0180;
  localparam logic [15:0] REG_IDX_MAP_STATUS      = 16'h0181;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] ROUTE_RESET       = 16'h0000;
  localparam logic [1:0]  MODE_RESET        = 2'h0;
  localparam logic        FULL_GROUP_RESET  = 1'b0;
  localparam int          CFG_MODE_LSB      = 0;
  localparam int          CFG_FULL_GROUP    = 4;
  localparam int          STATUS_COUNT_LSB  = 0;

  // ----------------------------------------------------------------
  // Port configuration modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_PORTS_8      = 2'h0;
  localparam logic [1:0]  MODE_PORTS_16     = 2'h1;
  localparam logic [1:0]  MODE_PORTS_32     = 2'h2;

  // ----------------------------------------------------------------
  // Map geometry and bus answers
  // ----------------------------------------------------------------
  localparam int          NUM_QUEUES        = 64;
  localparam int          QUEUES_PER_REG    = 16;
  localparam int          QUEUES_PER_GROUP  = 4;
  localparam int          HALF_QUEUES       = 32;
  localparam int          PORT_W            = 5;
  localparam int          COUNT_W           = 7;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_DECODE_ERROR = 2'h3;

endpackage : tqprm_pkg

// [hdl/tqprm_queue_port.sv]
// Destination port decode for one egress queue.
// Assumes routing bit and mode come from registers on the same clock.
`timescale 1ns/1ps
module tqprm_queue_port #(
  parameter int QUEUE = 0
) (
  // Configuration
  input  wire logic                          routeBit,
  input  wire logic [1:0]                    portMode,
  input  wire logic                          fullGroup,
  // Result
  output logic      [tqprm_pkg::PORT_W-1:0]  port,
  output logic                               valid
);

  localparam logic [3:0] GROUP = 4'(QUEUE / tqprm_pkg::QUEUES_PER_GROUP);
  localparam logic       UPPER = (QUEUE >= tqprm_pkg::HALF_QUEUES);

  // Queues above 31 are dropped outside 32-port mode unless 16-port mode sends whole groups to one port.
  always_comb begin
    if (portMode == tqprm_pkg::MODE_PORTS_32) begin
      port  = {GROUP, routeBit};
      valid = 1'b1;
    end else if ((portMode == tqprm_pkg::MODE_PORTS_16) && fullGroup) begin
      port  = {1'b0, GROUP};
      valid = 1'b1;
    end else begin
      port  = UPPER ? 5'h00 : {GROUP, routeBit};
      valid = !UPPER;
    end
  end

endmodule : tqprm_queue_port

// [testbench/tqprm_asserts.sv]
// Assertions on the register bus and queue map ports of the routing map.
// Assumes it is bound into tqprm_top and that the master holds each request.
`timescale 1ns/1ps
module tqprm_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic         read,
  input wire logic         write,
  input wire logic [31:0]  writedata,
  input wire logic [3:0]   byteenable,
  input wire logic [31:0]  readdata,
  input wire logic [1:0]   response,
  input wire logic         waitrequest,
  // Queue map
  input wire logic [tqprm_pkg::NUM_QUEUES*tqprm_pkg::PORT_W-1:0] queuePort,
  input wire logic [tqprm_pkg::NUM_QUEUES-1:0]                   queueValid
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_FIRST_WAIT: assert property (
    $rose(read || write) |-> waitrequest) else $error("access not stalled in first cycle");
  AST_ONE_STALL: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("access stalled beyond one cycle");
  AST_IDLE: assert property (
    !(read || write) |-> !waitrequest) else $error("waitrequest high while idle");
  AST_UPPER_ZERO: assert property (
    read && !waitrequest |-> readdata[31:16] == 16'h0000) else $error("upper read bytes not zero");
  AST_UNMAPPED: assert property (
    read && !waitrequest && address[1:0] != 2'h0 |-> response == tqprm_pkg::RESP_DECODE_ERROR
      && readdata == 32'h0) else $error("misaligned read not refused");
  AST_MAPPED_OK: assert property (
    read && !waitrequest && address == 12'h5e8 |-> response == tqprm_pkg::RESP_OKAY) else $error("bad read response");
  AST_MAP_HOLD: assert property (
    !$past(write && !waitrequest) |-> $stable(queuePort)) else $error("map changed without a write");
  AST_VALID_SET: assert property (
    &queueValid[31:0] && queueValid[47:32] inside {16'h0000, 16'hffff}) else $error("bad valid pattern");
  AST_Q16_PAIR: assert property (
    queuePort[84:80] inside {5'h04, 5'h08, 5'h09}) else $error("queue 16 outside its pair");
  AST_FULL_GROUP: assert property (
    queuePort[84:80] == 5'h04 |-> queuePort[89:85] == 5'h04 && &queueValid) else $error("group not whole");
  AST_Q47_PAIR: assert property (
    queueValid[47] |-> queuePort[239:235] inside {5'h0b, 5'h16, 5'h17}) else $error("queue 47 outside pair");
endmodule : tqprm_checker

bind tqprm_top tqprm_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .response(response), .waitrequest(waitrequest), .queuePort(queuePort), .queueValid(queueValid));

// [testbench/tqprm_tb_top.sv]
// Self-checking bench for the queue routing map register bank.
// Assumes the design answers every access after one stall cycle.
`timescale 1ns/1ps
module tqprm_tb_top;
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
    logic [4:0]  cfg;
    logic [5:0]  queue;
    logic [4:0]  port;
    logic        valid;
  } tqprm_row_t;
  // ----------------------------------------------------------------
  // Stimulus table: register, value, config, queue, port, valid
  // ----------------------------------------------------------------
  localparam tqprm_row_t ROWS [13] = '{
    '{12'h5e8, 16'haaaa, 5'h02, 6'h20, 5'h10, 1'b1},
    '{12'h5e8, 16'haaaa, 5'h02, 6'h23, 5'h11, 1'b1},
    '{12'h5e8, 16'haaaa, 5'h01, 6'h2f, 5'h00, 1'b0},
    '{12'h5f0, 16'h0000, 5'h00, 6'h13, 5'h08, 1'b1},
    '{12'h5f0, 16'haaaa, 5'h02, 6'h11, 5'h09, 1'b1},
    '{12'h5f0, 16'haaaa, 5'h11, 6'h12, 5'h04, 1'b1},
    '{12'h5f0, 16'haaaa, 5'h01, 6'h1f, 5'h0f, 1'b1},
    '{12'h5e8, 16'h0001, 5'h02, 6'h20, 5'h11, 1'b1},
    '{12'h5e8, 16'h8000, 5'h02, 6'h2f, 5'h17, 1'b1},
    '{12'h5f0, 16'h0001, 5'h02, 6'h10, 5'h09, 1'b1},
    '{12'h5f0, 16'h8000, 5'h02, 6'h1f, 5'h0f, 1'b1},
    '{12'h5e0, 16'h0001, 5'h02, 6'h30, 5'h19, 1'b1},
    '{12'h5f8, 16'h8000, 5'h00, 6'h0f, 5'h07, 1'b1}};
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [11:0]  address = 12'h000;
  logic         read = 1'b0;
  logic         write = 1'b0;
  logic [31:0]  writedata = 32'h0;
  logic [3:0]   byteenable = 4'hf;
  logic [31:0]  readdata;
  logic [1:0]   response;
  logic         waitrequest;
  logic [319:0] queuePort;
  logic [63:0]  queueValid;
  logic [31:0]  rd;
  logic [1:0]   rsp;
  int           failures = 0;
  int           checks = 0;
  always #4 core_clk = ~core_clk;
  tqprm_top #(.ADDR_W(12)) uut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .response(response), .waitrequest(waitrequest), .queuePort(queuePort), .queueValid(queueValid));
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      failures++;
      conclude();
    end
    rd = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].addr, {16'h0, ROWS[i].data});
      bus(1'b1, 12'h600, {27'h0, ROWS[i].cfg});
      bus(1'b0, ROWS[i].addr, 32'h0);
      chk(rd, {16'h0, ROWS[i].data});
      chk({30'h0, rsp}, {30'h0, tqprm_pkg::RESP_OKAY});
      chk({27'h0, queuePort[5*ROWS[i].queue +: 5]}, {27'h0, ROWS[i].port});
      chk({31'h0, queueValid[ROWS[i].queue]}, {31'h0, ROWS[i].valid});
      $display("row %0d done", i);
    end
    bus(1'b1, 12'h5f0, 32'h0001);
    @(negedge core_clk);
    chk({27'h0, queuePort[84:80]}, 32'h09);
    @(posedge core_clk);
    byteenable <= 4'h2;
    bus(1'b1, 12'h5f0, 32'hffff);
    byteenable <= 4'hf;
    bus(1'b1, 12'h5f1, 32'h1234);
    bus(1'b0, 12'h5f0, 32'h0);
    chk(rd, 32'hff01);
    bus(1'b0, 12'h5f1, 32'h0);
    chk({30'h0, rsp}, {30'h0, tqprm_pkg::RESP_DECODE_ERROR});
    bus(1'b0, 12'h700, 32'h0);
    chk({rd[29:0], rsp}, {30'h0, tqprm_pkg::RESP_DECODE_ERROR});
    bus(1'b1, 12'h600, 32'h0002);
    bus(1'b0, 12'h604, 32'h0);
    chk(rd, 32'h40);
    bus(1'b0, 12'h600, 32'h0);
    chk(rd, 32'h02);
    $display("bus edge cases done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, 12'h5e8, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h5f0, 32'h0);
    chk(rd, 32'h0);
    chk({queueValid[32], 26'h0, queuePort[84:80]}, 32'h08);
    bus(1'b0, 12'h604, 32'h0);
    chk(rd, 32'h20);
    $display("reset case done");
    conclude();
  end
endmodule : tqprm_tb_top
